// ===== include/nvm_guard_regs.vh
// Summary of operation
// [R01] power-up clears commit_enable
// [R02] no EEPROM write while power-up timer runs
// [R03] write needs commit_enable plus completed unlock
// [R04] software writes 55h then AAh first
// [R05] target_select_flash picks flash, else EEPROM
// [R06] flash word is value_high over value_low
// [R07] two instructions after commit are discarded
// [R08] core stalls, resumes at third instruction
// [R09] software writes flash in four-word blocks
// [R10] EEPROM protect blocks all outside EEPROM access
// [R11] EEPROM protect blocks outside flash writes
// [R12] flash protect keeps internal flash access working
// [R13] self-write guard bits block flash regions
// [R14] flash protect blocks all outside flash access
// [R15] unlock port stores nothing, reads zero
// [R16] software masks interrupts around unlock sequence
// [R17] completion clears commit trigger, sets done flag
// [R18] block programmed only on location bits 11
// [R19] core halted only during block erase
// [R20] flash fetch discards next two instructions
// [R21] broken unlock makes commit trigger ignored
`ifndef NVM_GUARD_REGS_VH
`define NVM_GUARD_REGS_VH

`define NVM_OFS_FLAGS_TWO     9'h00D
`define NVM_OFS_ENABLES_TWO   9'h08D
`define NVM_OFS_VALUE_LOW     9'h10C
`define NVM_OFS_LOCATION_LOW  9'h10D
`define NVM_OFS_VALUE_HIGH    9'h10E
`define NVM_OFS_LOCATION_HIGH 9'h10F
`define NVM_OFS_CONTROL       9'h18C
`define NVM_OFS_UNLOCK_PORT   9'h18D

`define NVM_BIT_TARGET_FLASH  7
`define NVM_BIT_COMMIT_FAULT  3
`define NVM_BIT_COMMIT_ENABLE 2
`define NVM_BIT_COMMIT_TRIG   1
`define NVM_BIT_FETCH_TRIG    0
`define NVM_BIT_DONE_FLAG     4

`define NVM_FLAGS_TWO_MASK    8'h59
`define NVM_RST_BYTE          8'h00

`define NVM_UNLOCK_FIRST      8'h55
`define NVM_UNLOCK_SECOND     8'hAA
`define NVM_BLOCK_LAST        2'h3

`define NVM_CLK_KHZ           100000
`define NVM_PWRT_TIME_MS      72
`define NVM_PWRT_CYCLES       (`NVM_PWRT_TIME_MS * `NVM_CLK_KHZ)
`define NVM_ERASE_TIME_MS     4
`define NVM_ERASE_CYCLES      (`NVM_ERASE_TIME_MS * `NVM_CLK_KHZ)
`define NVM_EE_WRITE_CYCLES   1000
`define NVM_SQUASH_CYCLES     2'h2

`endif

// ===== rtl/nvm_unlock_detect.v
`timescale 1ns/1ps
`include "nvm_guard_regs.vh"
module nvm_unlock_detect (
  input  wire       i_sys_clk,
  input  wire       i_sys_rst,
  input  wire       i_wr_unlock,
  input  wire [7:0] i_wdata,
  input  wire       i_wr_other,
  output reg        o_armed
);
  localparam ST_IDLE  = 2'h0;
  localparam ST_FIRST = 2'h1;
  localparam ST_ARMED = 2'h2;

  reg [1:0] state;

  // no storage: only the pattern of writes is tracked
  always @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      state <= ST_IDLE;
    end else if (i_wr_unlock) begin
      case (state)
        ST_IDLE:  state <= (i_wdata == `NVM_UNLOCK_FIRST) ? ST_FIRST : ST_IDLE; // R15
        ST_FIRST: state <= (i_wdata == `NVM_UNLOCK_SECOND) ? ST_ARMED : ST_IDLE; // R21
        default:  state <= ST_IDLE;
      endcase
    end else if (i_wr_other) begin
      // any other write breaks the sequence, though cycles with no write may fall between the steps
      state <= ST_IDLE; // R21
    end
  end

  always @* begin
    o_armed = (state == ST_ARMED);
  end
endmodule

// ===== rtl/nvm_timer.v
`timescale 1ns/1ps
module nvm_timer #(
  parameter W = 23
) (
  input  wire         i_sys_clk,
  input  wire         i_sys_rst,
  input  wire         i_load,
  input  wire [W-1:0] i_count,
  output reg          o_busy,
  output reg          o_done
);
  reg [W-1:0] count;

  always @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      count  <= {W{1'b0}};
      o_busy <= 1'b0;
      o_done <= 1'b0;
    end else if (i_load) begin
      count  <= i_count;
      o_busy <= 1'b1;
      o_done <= 1'b0;
    end else if (o_busy) begin
      count  <= count - {{(W-1){1'b0}}, 1'b1};
      o_busy <= (count > {{(W-1){1'b0}}, 1'b1});
      o_done <= (count <= {{(W-1){1'b0}}, 1'b1});
    end else begin
      o_done <= 1'b0;
    end
  end
endmodule

// ===== rtl/nvm_self_program_guard.v
`timescale 1ns/1ps
`include "nvm_guard_regs.vh"
module nvm_self_program_guard #(
  parameter        EE_DEPTH     = 256,
  parameter        PM_DEPTH     = 8192,
  parameter [22:0] PWRT_CYCLES  = `NVM_PWRT_CYCLES,
  parameter [22:0] ERASE_CYCLES = `NVM_ERASE_CYCLES,
  parameter [22:0] EE_CYCLES    = `NVM_EE_WRITE_CYCLES,
  parameter [12:0] GUARD_LIMIT0 = 13'h1000,
  parameter [12:0] GUARD_LIMIT1 = 13'h0800,
  parameter [12:0] GUARD_LIMIT2 = 13'h0100
) (
  input  wire        i_sys_clk,
  input  wire        i_sys_rst,
  input  wire [8:0]  i_reg_addr,
  input  wire        i_reg_wr,
  input  wire        i_reg_rd,
  input  wire [7:0]  i_reg_wdata,
  output reg  [7:0]  o_reg_rdata,
  input  wire        i_cfg_ee_protect,
  input  wire        i_cfg_pm_protect,
  input  wire [1:0]  i_cfg_self_guard,
  input  wire        i_ext_req,
  input  wire        i_ext_wr,
  input  wire        i_ext_flash,
  input  wire [12:0] i_ext_addr,
  input  wire [13:0] i_ext_wdata,
  output reg         o_ext_ack,
  output reg         o_ext_refused,
  output reg  [13:0] o_ext_rdata,
  output reg         o_core_squash,
  output reg         o_core_stall,
  output reg         o_nvm_irq
);
  localparam ST_IDLE  = 3'h0;
  localparam ST_EE_WR = 3'h1;
  localparam ST_PM_LD = 3'h2;
  localparam ST_PM_BK = 3'h3;
  localparam ST_ERASE = 3'h4;
  localparam ST_FETCH = 3'h5;

  reg [7:0]  value_low;
  reg [5:0]  value_high;
  reg [7:0]  location_low;
  reg [4:0]  location_high;
  reg        target_select_flash;
  reg        commit_fault;
  reg        commit_enable;
  reg        commit_trigger;
  reg        fetch_trigger;
  reg [7:0]  flags_two;
  reg [7:0]  enables_two;
  reg [2:0]  state;
  reg [1:0]  squash_cnt;
  reg [12:0] op_addr;
  reg [7:0]  op_ee_data;

  reg [7:0]  ee_mem [0:EE_DEPTH-1];
  reg [13:0] pm_mem [0:PM_DEPTH-1];
  reg [13:0] pm_buf [0:3];

  reg        ext_req_s1;
  reg        ext_req_s2;
  reg        ext_req_s3;
  reg        ext_wr_s1;
  reg        ext_wr_s2;
  reg        ext_fl_s1;
  reg        ext_fl_s2;

  wire        armed;
  wire        pwrt_busy;
  wire        wt_done;
  wire        wt_busy;
  wire [12:0] loc = {location_high, location_low};
  wire        wr_unlock = i_reg_wr && (i_reg_addr == `NVM_OFS_UNLOCK_PORT);
  wire        wr_ctrl = i_reg_wr && (i_reg_addr == `NVM_OFS_CONTROL);
  wire        commit_req = wr_ctrl && i_reg_wdata[`NVM_BIT_COMMIT_TRIG]
                           && (state == ST_IDLE);
  wire        fetch_req = wr_ctrl && i_reg_wdata[`NVM_BIT_FETCH_TRIG]
                          && !i_reg_wdata[`NVM_BIT_COMMIT_TRIG]
                          && (state == ST_IDLE);
  wire        tgt_flash = i_reg_wdata[`NVM_BIT_TARGET_FLASH];
  wire        last_word = (location_low[1:0] == `NVM_BLOCK_LAST);
  wire        ext_go = ext_req_s2 && !ext_req_s3;
  reg  [12:0] guard_limit;
  reg         commit_ok;
  reg         fetch_go;
  reg  [13:0] fetch_word;

  nvm_unlock_detect u_unlock (
    .i_sys_clk   (i_sys_clk),
    .i_sys_rst   (i_sys_rst),
    .i_wr_unlock (wr_unlock),
    .i_wdata     (i_reg_wdata),
    .i_wr_other  (i_reg_wr && !wr_unlock),
    .o_armed     (armed)
  );

  // restarted by every reset, so the window also covers brown-out
  nvm_timer #(.W(23)) u_pwrt (
    .i_sys_clk (i_sys_clk),
    .i_sys_rst (1'b0),
    .i_load    (i_sys_rst),
    .i_count   (PWRT_CYCLES),
    .o_busy    (pwrt_busy),
    .o_done    ()
  );

  // erase timed from one cycle before the stall, so it spans ERASE_CYCLES
  nvm_timer #(.W(23)) u_wtimer (
    .i_sys_clk (i_sys_clk),
    .i_sys_rst (i_sys_rst),
    .i_load    ((commit_req && commit_ok && !tgt_flash)
                || (state == ST_PM_BK
                    && squash_cnt == `NVM_SQUASH_CYCLES)),
    .i_count   ((state == ST_PM_BK) ? ERASE_CYCLES : EE_CYCLES),
    .o_busy    (wt_busy),
    .o_done    (wt_done)
  );

  always @* begin
    case (i_cfg_self_guard)
      2'h0:    guard_limit = GUARD_LIMIT0;
      2'h1:    guard_limit = GUARD_LIMIT1;
      2'h2:    guard_limit = GUARD_LIMIT2;
      default: guard_limit = 13'h0000;
    endcase
    // needs the unlock and commit_enable in the same write
    commit_ok = armed && i_reg_wdata[`NVM_BIT_COMMIT_ENABLE]; // R03
    if (!tgt_flash && pwrt_busy) begin
      commit_ok = 1'b0; // R02
    end
    if (tgt_flash && last_word && (loc < guard_limit)) begin
      commit_ok = 1'b0; // R13
    end
    fetch_go = (state == ST_FETCH) && (squash_cnt == 2'h1);
    fetch_word = pm_mem[loc]; // R12
  end

  always @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      target_select_flash <= 1'b0;
      commit_fault        <= 1'b0;
      commit_enable       <= 1'b0; // R01
      commit_trigger      <= 1'b0;
      fetch_trigger       <= 1'b0;
      flags_two           <= `NVM_RST_BYTE;
      enables_two         <= `NVM_RST_BYTE;
      value_low           <= `NVM_RST_BYTE;
      value_high          <= 6'h00;
      location_low        <= `NVM_RST_BYTE;
      location_high       <= 5'h00;
      state               <= ST_IDLE;
      squash_cnt          <= 2'h0;
      op_addr             <= 13'h0000;
      op_ee_data          <= `NVM_RST_BYTE;
    end else begin
      if (i_reg_wr) begin
        case (i_reg_addr)
          `NVM_OFS_VALUE_LOW:     value_low <= i_reg_wdata;
          `NVM_OFS_VALUE_HIGH:    value_high <= i_reg_wdata[5:0];
          `NVM_OFS_LOCATION_LOW:  location_low <= i_reg_wdata;
          `NVM_OFS_LOCATION_HIGH: location_high <= i_reg_wdata[4:0];
          `NVM_OFS_ENABLES_TWO:   enables_two <= i_reg_wdata;
          `NVM_OFS_FLAGS_TWO:     flags_two <= i_reg_wdata;
          `NVM_OFS_CONTROL: begin
            target_select_flash <= tgt_flash; // R05
            commit_enable <= i_reg_wdata[`NVM_BIT_COMMIT_ENABLE];
            commit_fault  <= i_reg_wdata[`NVM_BIT_COMMIT_FAULT];
          end
          default: ;
        endcase
      end
      if (squash_cnt != 2'h0) begin
        squash_cnt <= squash_cnt - 2'h1;
      end
      case (state)
        ST_IDLE: begin
          if (commit_req && commit_ok) begin
            commit_trigger <= 1'b1;
            op_addr        <= loc;
            op_ee_data     <= value_low;
            if (tgt_flash) begin
              squash_cnt <= `NVM_SQUASH_CYCLES; // R07
              state      <= last_word ? ST_PM_BK : ST_PM_LD; // R18
            end else begin
              state <= ST_EE_WR;
            end
          end else if (commit_req) begin
            // refused commit leaves memory alone and flags the fault
            commit_fault <= 1'b1; // R21
          end else if (fetch_req) begin
            fetch_trigger <= 1'b1;
            if (tgt_flash) begin
              squash_cnt <= `NVM_SQUASH_CYCLES; // R20
              state      <= ST_FETCH;
            end else begin
              value_low     <= ee_mem[location_low];
              fetch_trigger <= 1'b0;
            end
          end
        end
        ST_EE_WR: begin
          if (wt_done) begin
            commit_trigger <= 1'b0; // R17
            flags_two[`NVM_BIT_DONE_FLAG] <= 1'b1; // R17
            state <= ST_IDLE;
          end
        end
        ST_PM_LD: begin
          // buffer load only, appears instant to software
          if (squash_cnt == 2'h1) begin
            commit_trigger <= 1'b0;
            flags_two[`NVM_BIT_DONE_FLAG] <= 1'b1;
            state <= ST_IDLE;
          end
        end
        ST_PM_BK: begin
          if (squash_cnt == 2'h1) begin
            state <= ST_ERASE; // R19
          end
        end
        ST_ERASE: begin
          // release lands the core on the third instruction
          if (wt_done) begin
            commit_trigger <= 1'b0; // R08
            flags_two[`NVM_BIT_DONE_FLAG] <= 1'b1;
            state <= ST_IDLE;
          end
        end
        ST_FETCH: begin
          if (fetch_go) begin
            value_low     <= fetch_word[7:0];
            value_high    <= fetch_word[13:8];
            fetch_trigger <= 1'b0;
            state         <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // memory arrays carry no reset
  always @(posedge i_sys_clk) begin
    if (!i_sys_rst && (state == ST_IDLE) && commit_req && commit_ok
        && tgt_flash) begin
      pm_buf[location_low[1:0]] <= {value_high, value_low}; // R06
    end
    if (!i_sys_rst && (state == ST_EE_WR) && wt_done) begin
      ee_mem[op_addr[7:0]] <= op_ee_data;
    end
    if (!i_sys_rst && (state == ST_ERASE) && wt_done) begin
      pm_mem[{op_addr[12:2], 2'h0}] <= pm_buf[0];
      pm_mem[{op_addr[12:2], 2'h1}] <= pm_buf[1];
      pm_mem[{op_addr[12:2], 2'h2}] <= pm_buf[2];
      pm_mem[{op_addr[12:2], 2'h3}] <= pm_buf[3];
    end
    if (!i_sys_rst && ext_go && ext_wr_s2 && !o_core_stall) begin
      if (ext_fl_s2 && !i_cfg_pm_protect && !i_cfg_ee_protect) begin
        pm_mem[i_ext_addr] <= i_ext_wdata; // R11
      end
      if (!ext_fl_s2 && !i_cfg_ee_protect) begin
        ee_mem[i_ext_addr[7:0]] <= i_ext_wdata[7:0]; // R10
      end
    end
  end

  // external strobes come from pins, so two flops before use
  always @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      ext_req_s1    <= 1'b0;
      ext_req_s2    <= 1'b0;
      ext_req_s3    <= 1'b0;
      ext_wr_s1     <= 1'b0;
      ext_wr_s2     <= 1'b0;
      ext_fl_s1     <= 1'b0;
      ext_fl_s2     <= 1'b0;
      o_ext_ack     <= 1'b0;
      o_ext_refused <= 1'b0;
      o_ext_rdata   <= 14'h0000;
    end else begin
      ext_req_s1    <= i_ext_req;
      ext_req_s2    <= ext_req_s1;
      ext_req_s3    <= ext_req_s2;
      ext_wr_s1     <= i_ext_wr;
      ext_wr_s2     <= ext_wr_s1;
      ext_fl_s1     <= i_ext_flash;
      ext_fl_s2     <= ext_fl_s1;
      o_ext_ack     <= 1'b0;
      o_ext_refused <= 1'b0;
      if (ext_go) begin
        // protection is checked per access, never latched
        if (o_core_stall
            || (ext_fl_s2 && i_cfg_pm_protect) // R14
            || (ext_fl_s2 && ext_wr_s2 && i_cfg_ee_protect) // R11
            || (!ext_fl_s2 && i_cfg_ee_protect)) begin // R10
          o_ext_refused <= 1'b1;
          o_ext_rdata   <= 14'h0000;
        end else begin
          o_ext_ack <= 1'b1;
          if (!ext_wr_s2) begin
            o_ext_rdata <= ext_fl_s2 ? pm_mem[i_ext_addr]
                                     : {6'h00, ee_mem[i_ext_addr[7:0]]};
          end
        end
      end
    end
  end

  always @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_reg_rdata   <= `NVM_RST_BYTE;
      o_core_squash <= 1'b0;
      o_core_stall  <= 1'b0;
      o_nvm_irq     <= 1'b0;
    end else begin
      // the last count is the resume cycle, which is not discarded
      o_core_squash <= (squash_cnt > 2'h1) ||
                       ((commit_req && commit_ok && tgt_flash)
                        || (fetch_req && tgt_flash)); // R07
      o_core_stall  <= (state == ST_PM_BK && squash_cnt == 2'h1)
                       || (state == ST_ERASE && !wt_done); // R19
      o_nvm_irq     <= flags_two[`NVM_BIT_DONE_FLAG]
                       && enables_two[`NVM_BIT_DONE_FLAG];
      if (i_reg_rd) begin
        case (i_reg_addr)
          `NVM_OFS_VALUE_LOW:     o_reg_rdata <= value_low;
          `NVM_OFS_VALUE_HIGH:    o_reg_rdata <= {2'h0, value_high};
          `NVM_OFS_LOCATION_LOW:  o_reg_rdata <= location_low;
          `NVM_OFS_LOCATION_HIGH: o_reg_rdata <= {3'h0, location_high};
          `NVM_OFS_FLAGS_TWO:
            o_reg_rdata <= flags_two & `NVM_FLAGS_TWO_MASK;
          `NVM_OFS_ENABLES_TWO:
            o_reg_rdata <= enables_two & `NVM_FLAGS_TWO_MASK;
          `NVM_OFS_CONTROL:
            o_reg_rdata <= {target_select_flash, 3'h0, commit_fault,
                            commit_enable, commit_trigger, fetch_trigger};
          default:                o_reg_rdata <= `NVM_RST_BYTE; // R15
        endcase
      end
    end
  end
endmodule

// ===== dv/nvm_guard_props.sv
`timescale 1ns/1ps
`include "nvm_guard_regs.vh"
module nvm_guard_props #(
  parameter [22:0] ERASE_CYCLES = 23'h00000A
) (
  input wire       i_sys_clk,
  input wire       i_sys_rst,
  input wire [8:0] i_reg_addr,
  input wire       i_reg_wr,
  input wire       i_reg_rd,
  input wire [7:0] i_reg_wdata,
  input wire [7:0] o_reg_rdata,
  input wire       i_cfg_ee_protect,
  input wire       i_cfg_pm_protect,
  input wire [1:0] i_cfg_self_guard,
  input wire       i_ext_req,
  input wire       i_ext_wr,
  input wire       i_ext_flash,
  input wire       o_ext_ack,
  input wire       o_ext_refused,
  input wire       o_core_squash,
  input wire       o_core_stall,
  input wire       o_nvm_irq
);
  reg        en_q;
  reg [22:0] st_n;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);
  // mirror of the done-irq enable, and run length of the current stall
  always @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      en_q <= 1'b0;
      st_n <= 23'h000000;
    end else begin
      if (i_reg_wr && i_reg_addr == `NVM_OFS_ENABLES_TWO)
        en_q <= i_reg_wdata[4];
      st_n <= o_core_stall ? st_n + 23'h000001 : 23'h000000;
    end
  end
  sequence s_key;
    i_reg_wr && i_reg_addr == `NVM_OFS_UNLOCK_PORT &&
      i_reg_wdata == `NVM_UNLOCK_FIRST ##1
    i_reg_wr && i_reg_addr == `NVM_OFS_UNLOCK_PORT &&
      i_reg_wdata == `NVM_UNLOCK_SECOND;
  endsequence
  // guarded commits and those during a stall or squash excluded: their squash is not promised
  sequence s_flash_commit;
    s_key ##1 (i_reg_wr && i_reg_addr == `NVM_OFS_CONTROL &&
      i_reg_wdata[7] && i_reg_wdata[2:1] == 2'h3 && !o_core_stall &&
      !o_core_squash && i_cfg_self_guard == 2'h3);
  endsequence
  sequence s_two_squash;
    o_core_squash [*2] ##1 !o_core_squash;
  endsequence
  AST_COMMIT_SQUASH: assert property (s_flash_commit |=> s_two_squash)
    else $error("flash commit not followed by two squash cycles");
  AST_FETCH_SQUASH: assert property (i_reg_wr && i_reg_wdata == 8'h81 &&
    i_reg_addr == `NVM_OFS_CONTROL && !o_core_stall && !o_core_squash
    |=> s_two_squash) else $error("fetch not followed by two squashes");
  AST_SQUASH_LEN: assert property ($rose(o_core_squash) |-> s_two_squash)
    else $error("squash burst not two cycles");
  AST_STALL_CAUSE: assert property ($rose(o_core_stall) |->
    $past(o_core_squash)) else $error("stall without preceding squash");
  AST_STALL_LEN: assert property ($fell(o_core_stall) |->
    st_n == ERASE_CYCLES) else $error("stall length wrong");
  AST_STALL_MAX: assert property (st_n <= ERASE_CYCLES)
    else $error("stall too long");
  AST_UNLOCK_READS_ZERO: assert property (i_reg_rd &&
    i_reg_addr == `NVM_OFS_UNLOCK_PORT |=> o_reg_rdata == 8'h00)
    else $error("unlock port read not zero");
  AST_IRQ_MASKED: assert property (!en_q |=> !o_nvm_irq)
    else $error("irq while disabled");
  AST_EE_PROTECT: assert property ($rose(i_ext_req) && i_cfg_ee_protect &&
    !i_ext_flash |-> ##[1:4] o_ext_refused) else $error("ee access allowed");
  AST_EE_FLASH_WR: assert property ($rose(i_ext_req) && i_cfg_ee_protect &&
    i_ext_flash && i_ext_wr |-> ##[1:4] o_ext_refused)
    else $error("flash write allowed under ee protect");
  AST_PM_PROTECT: assert property ($rose(i_ext_req) && i_cfg_pm_protect &&
    i_ext_flash |-> ##[1:4] o_ext_refused) else $error("flash access allowed");
endmodule

bind nvm_self_program_guard nvm_guard_props #(
  .ERASE_CYCLES(ERASE_CYCLES)
) u_nvm_guard_props (
  .i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_reg_addr(i_reg_addr),
  .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_wdata(i_reg_wdata),
  .o_reg_rdata(o_reg_rdata), .i_cfg_ee_protect(i_cfg_ee_protect),
  .i_cfg_pm_protect(i_cfg_pm_protect), .i_cfg_self_guard(i_cfg_self_guard),
  .i_ext_req(i_ext_req), .i_ext_wr(i_ext_wr), .i_ext_flash(i_ext_flash),
  .o_ext_ack(o_ext_ack), .o_ext_refused(o_ext_refused),
  .o_core_squash(o_core_squash), .o_core_stall(o_core_stall),
  .o_nvm_irq(o_nvm_irq)
);

// ===== dv/tb.sv
`timescale 1ns/1ps
`include "nvm_guard_regs.vh"
`define CHK(nm, e, s) begin checks++; if ((s) !== (e)) begin n_errors++; \
  $display("ERROR %s expected %h seen %h", nm, e, s); end end
module tb;
  localparam ERA = 10;
  localparam EEC = 5;
  localparam [8:0] CTL = `NVM_OFS_CONTROL;
  localparam [8:0] UNL = `NVM_OFS_UNLOCK_PORT;
  localparam [8:0] VLO = `NVM_OFS_VALUE_LOW;
  localparam [8:0] VHI = `NVM_OFS_VALUE_HIGH;
  localparam [8:0] LLO = `NVM_OFS_LOCATION_LOW;
  localparam [8:0] LHI = `NVM_OFS_LOCATION_HIGH;
  reg         i_sys_clk = 1'b0;
  reg         i_sys_rst = 1'b1;
  reg  [8:0]  i_reg_addr = 9'h000;
  reg         i_reg_wr = 1'b0;
  reg         i_reg_rd = 1'b0;
  reg  [7:0]  i_reg_wdata = 8'h00;
  reg         i_cfg_ee_protect = 1'b1;
  reg         i_cfg_pm_protect = 1'b1;
  reg  [1:0]  i_cfg_self_guard = 2'h3;
  reg         i_ext_req = 1'b0;
  reg         i_ext_wr = 1'b0;
  reg         i_ext_flash = 1'b0;
  reg  [12:0] i_ext_addr = 13'h0000;
  reg  [13:0] i_ext_wdata = 14'h0000;
  wire [7:0]  o_reg_rdata;
  wire [13:0] o_ext_rdata;
  wire        o_ext_ack, o_ext_refused, o_core_squash, o_core_stall, o_nvm_irq;
  integer     n_errors = 0;
  integer     checks = 0;
  integer     i, k, g;
  reg         rd_pend = 1'b0;
  reg  [15:0] t;
  reg  [28:0] u;
  reg  [15:0] rq[$];
  reg  [28:0] xq[$];
  reg  [31:0] rnd = 32'h6EA80E21;
  reg  [7:0]  ee_byte, hi, lo;
  reg  [13:0] w[0:3];
  reg         f, wx, rf;

  nvm_self_program_guard #(.PWRT_CYCLES(23'h000014),
    .ERASE_CYCLES(23'h00000A), .EE_CYCLES(23'h000005)) u_nvm_self_program_guard (
    .i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_reg_addr(i_reg_addr),
    .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_wdata(i_reg_wdata),
    .o_reg_rdata(o_reg_rdata), .i_cfg_ee_protect(i_cfg_ee_protect),
    .i_cfg_pm_protect(i_cfg_pm_protect), .i_cfg_self_guard(i_cfg_self_guard),
    .i_ext_req(i_ext_req), .i_ext_wr(i_ext_wr), .i_ext_flash(i_ext_flash),
    .i_ext_addr(i_ext_addr), .i_ext_wdata(i_ext_wdata), .o_ext_ack(o_ext_ack),
    .o_ext_refused(o_ext_refused), .o_ext_rdata(o_ext_rdata),
    .o_core_squash(o_core_squash), .o_core_stall(o_core_stall),
    .o_nvm_irq(o_nvm_irq));

  always #5 i_sys_clk = ~i_sys_clk;

  function [31:0] xs(input [31:0] x);
    begin
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      xs = x ^ (x << 5);
    end
  endfunction

  // strobe left high, so back-to-back writes keep it asserted without a gap
  task wr(input [8:0] a, input [7:0] d);
    begin
      i_reg_addr <= a;
      i_reg_wdata <= d;
      i_reg_wr <= 1'b1;
      @(posedge i_sys_clk);
    end
  endtask
  task idle(input integer n);
    begin
      i_reg_wr <= 1'b0;
      repeat (n) @(posedge i_sys_clk);
    end
  endtask
  task rd(input [8:0] a, input [7:0] m, input [7:0] e);
    begin
      i_reg_wr <= 1'b0;
      i_reg_addr <= a;
      i_reg_rd <= 1'b1;
      rq.push_back({m, e});
      @(posedge i_sys_clk);
      i_reg_rd <= 1'b0;
      @(posedge i_sys_clk);
    end
  endtask
  task commit(input [7:0] c);
    begin
      wr(UNL, `NVM_UNLOCK_FIRST);
      wr(UNL, `NVM_UNLOCK_SECOND);
      wr(CTL, c);
      idle(4);
    end
  endtask
  task wblk;
    for (k = 0; k < 4; k++) begin
      wr(LHI, hi);
      wr(LLO, lo + k[7:0]);
      wr(VLO, w[k][7:0]);
      wr(VHI, {2'h0, w[k][13:8]});
      commit(8'h86);
      if (k == 3) idle(ERA + 4);
    end
  endtask
  task cblk;
    for (k = 0; k < 4; k++) begin
      wr(LHI, hi);
      wr(LLO, lo + k[7:0]);
      wr(CTL, 8'h81);
      idle(4);
      rd(VLO, 8'hFF, w[k][7:0]);
      rd(VHI, 8'h3F, {2'h0, w[k][13:8]});
    end
  endtask
  task ext(input [12:0] a, input [13:0] d, input [13:0] m, input [13:0] e);
    integer n;
    begin
      n = 0;
      i_ext_wr <= wx;
      i_ext_flash <= f;
      i_ext_addr <= a;
      i_ext_wdata <= d;
      i_ext_req <= 1'b1;
      xq.push_back({rf, m, e});
      @(posedge i_sys_clk);
      while (!(o_ext_ack | o_ext_refused) && n < 10) begin
        @(posedge i_sys_clk);
        n++;
      end
      `CHK("ext answer", 1'b1, o_ext_ack | o_ext_refused)
      i_ext_req <= 1'b0;
      repeat (4) @(posedge i_sys_clk);
    end
  endtask
  task report_and_stop;
    begin
      $display("checks %0d n_errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask

  always @(posedge i_sys_clk) begin
    rd_pend <= i_reg_rd;
    if (rd_pend) begin
      t = rq.pop_front();
      `CHK("reg read", t[7:0], o_reg_rdata & t[15:8])
    end
    if (o_ext_ack | o_ext_refused) begin
      u = xq.pop_front();
      `CHK("ext reply", u, {o_ext_refused, u[27:14], o_ext_rdata & u[27:14]})
    end
  end

  initial begin
    repeat (30000) @(posedge i_sys_clk);
    n_errors++;
    report_and_stop;
  end

  initial begin
    repeat (10) @(posedge i_sys_clk);
    i_sys_rst <= 1'b0;
    @(posedge i_sys_clk);
    rd(CTL, 8'hFF, 8'h00);
    wr(LLO, 8'h3C);
    commit(8'h06);
    rd(CTL, 8'h0A, 8'h08);
    idle(25);
    rd(UNL, 8'hFF, 8'h00);
    rd(9'h001, 8'hFF, 8'h00);
    rnd = xs(rnd);
    ee_byte = rnd[7:0];
    wr(VLO, ee_byte);
    commit(8'h06);
    idle(EEC + 3);
    rd(CTL, 8'h02, 8'h00);
    rd(`NVM_OFS_FLAGS_TWO, 8'h10, 8'h10);
    wr(`NVM_OFS_ENABLES_TWO, 8'h10);
    idle(2);
    `CHK("irq set", 1'b1, o_nvm_irq)
    wr(`NVM_OFS_FLAGS_TWO, 8'h00);
    idle(2);
    `CHK("irq clear", 1'b0, o_nvm_irq)
    // broken unlock variants, then a clean unlock without enable
    for (i = 0; i < 4; i++) begin
      wr(VLO, ~ee_byte);
      wr(UNL, i == 1 ? 8'hAA : 8'h55);
      if (i == 0) wr(LLO, 8'h3C);
      wr(UNL, i == 3 || i == 0 ? 8'hAA : 8'h55);
      wr(CTL, i == 3 ? 8'h02 : 8'h06);
      idle(EEC + 3);
      if (i < 3) rd(CTL, 8'h08, 8'h08);
      wr(CTL, 8'h01);
      idle(2);
      rd(VLO, 8'hFF, ee_byte);
    end
    // guard settings 0 to 2 must each protect a block just below their limit
    for (g = 0; g < 3; g++) begin
      for (k = 0; k < 4; k++) begin
        rnd = xs(rnd);
        w[k] = rnd[13:0];
      end
      hi = g == 0 ? 8'h0F : g == 1 ? 8'h07 : 8'h00;
      lo = rnd[23:16] & 8'hFC;
      i_cfg_self_guard <= 2'h3;
      wblk;
      i_cfg_self_guard <= g[1:0];
      for (k = 0; k < 4; k++) w[k] = ~w[k];
      wblk;
      for (k = 0; k < 4; k++) w[k] = ~w[k];
      cblk;
    end
    for (i = 0; i < 16; i++) begin
      {i_cfg_ee_protect, i_cfg_pm_protect} <= i[3:2];
      {f, wx} = i[1:0];
      rf = (i[2] & i[1]) | (i[3] & (~i[1] | i[0]));
      ext(i[1] ? {hi[4:0], lo} : 13'h003C, i[1] ? w[0] : {6'h00, ee_byte},
        (i[0] & ~rf) ? 14'h0000 : 14'h3FFF,
        (rf | i[0]) ? 14'h0000 : i[1] ? w[0] : {6'h00, ee_byte});
    end
    report_and_stop;
  end
endmodule
